// file: fsfb_pkg.sv
// constants, types and register map of the fault status flag bank
package fsfb_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int CONV_W = 6;
  localparam int DIG_W = 4;
  localparam int IRQ_W = CONV_W + DIG_W;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] CONV_IDX = 10'h004;
  localparam logic [9:0] DIG_IDX = 10'h005;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h008;
  localparam logic [9:0] IRQ_CLR_IDX = 10'h009;
  localparam logic [9:0] IRQ_EN_IDX = 10'h00A;

  // ==========================================================
  // converter and clock fault register layout
  localparam logic [15:0] CONV_RESET = 16'hFC07;
  localparam logic [15:0] CONV_RSVD = 16'h1C00;
  localparam int CONV_SHUNT_A_BIT = 15;
  localparam int CONV_SHUNT_B_BIT = 14;
  localparam int CONV_AUX_BIT = 13;
  localparam int CONV_FREQ_BIT = 2;
  localparam int CONV_DIAG_WD_BIT = 1;
  localparam int CONV_MAIN_WD_BIT = 0;

  // ==========================================================
  // digital integrity register layout
  localparam logic [15:0] DIG_RESET = 16'hEC00;
  localparam int DIG_REGION_ONE_BIT = 15;
  localparam int DIG_REGION_TWO_BIT = 14;
  localparam int DIG_REGION_THREE_BIT = 13;
  localparam int DIG_ZERO_BIT = 12;
  localparam int DIG_MEMORY_BIT = 11;
  localparam int DIG_OTP_BANK_BIT = 10;
  localparam logic OTP_BANK_RESET = 1'h1;

  // ==========================================================
  // interrupt registers and bus answers
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // fault detections, high for one or more cycles per fault
  typedef struct packed {
    logic shunt_a;
    logic shunt_b;
    logic aux;
    logic freq;
    logic diag_wd;
    logic main_wd;
  } fsfb_conv_fault_s;

  typedef struct packed {
    logic region_one;
    logic region_two;
    logic region_three;
    logic internal_memory;
  } fsfb_dig_fault_s;

  typedef enum {
    SEL_CONV,
    SEL_DIG,
    SEL_IRQ_STAT,
    SEL_IRQ_CLR,
    SEL_IRQ_EN,
    SEL_NONE
  } fsfb_sel_e;

endpackage

// file: fsfb_flag_bank.sv
// bank of active-low sticky fault flags with write-one restore
module fsfb_flag_bank #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] fault,
  input wire logic [W-1:0] restore,
  output logic [W-1:0] flag_n
);

  logic [W-1:0] flag_n_ff;

  // ==========================================================
  // one flag per bit, detection beats restore so no fault is lost
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_n_ff[i] <= 1'h1;
      end else if (ce) begin
        if (fault[i]) begin
          flag_n_ff[i] <= 1'h0; // RULE14
        end else if (restore[i]) begin
          flag_n_ff[i] <= 1'h1; // RULE4
        end
      end
    end
  end

  assign flag_n = flag_n_ff;

  // ==========================================================
  // checks
  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
    ce && |(restore & ~fault) |=>
      (flag_n_ff & $past(restore & ~fault)) == $past(restore & ~fault);
  endproperty
  a_restore: assert property (p_restore) // RULE4
    else $error("restoring write did not return flag to one");

  property p_fault_wins;
    @(posedge aclk) disable iff (!aresetn)
    ce && |(fault & restore) |=> (flag_n_ff & $past(fault)) == '0;
  endproperty
  a_fault_wins: assert property (p_fault_wins) // RULE14
    else $error("fault lost against a restoring write");

  property p_hold_without_write;
    @(posedge aclk) disable iff (!aresetn)
    ce && (fault | restore) == '0 |=> $stable(flag_n_ff);
  endproperty
  a_hold_without_write: assert property (p_hold_without_write) // RULE14
    else $error("flag moved with no fault and no restore");

endmodule

// file: fsfb_top.sv
// fault status flag bank with axi4-lite register slave and interrupt
//
// How it works
// RULE1: bit 15 latches low on first shunt converter overrange; high means none.
// RULE2: bit 14 latches low on second shunt converter overrange, else reads one.
// RULE3: bit 13 latches low on auxiliary converter overrange, else reads one.
// RULE4: a flag stays low until software writes one there, restoring it.
// RULE5: bit 2 latches low when main clock frequency leaves its window.
// RULE6: bit 1 latches low on diagnostic oscillator watchdog fault.
// RULE7: bit 0 latches low on main clock watchdog fault.
// RULE8: converter register at 04h, reset FC07h, bits 12..3 fixed.
// RULE9: integrity register at 05h, resets to EC00h.
// RULE10: bits 15..13,11 writable flags; 12 zero; 10 read-only; 9..0 zero.
// RULE11: bits 15,14,13 latch low on region checksum mismatch.
// RULE12: bit 11 latches low on internal memory checksum failure.
// RULE13: bit 10 shows loaded bank, one primary; not a fault event.
// RULE14: writing zero leaves a flag; fault beats a same-cycle restore.
//
// The AXI4-Lite slave port is this design's own decision.
module fsfb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // fault detectors and bank loader, same clock domain
  input wire fsfb_pkg::fsfb_conv_fault_s conv_fault,
  input wire fsfb_pkg::fsfb_dig_fault_s dig_fault,
  input wire logic otp_bank_primary,
  // axi4-lite slave
  input wire logic [fsfb_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [fsfb_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [fsfb_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [fsfb_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt
  output logic irq
);

  // ==========================================================
  // address decode, shared by the read and write paths
  function automatic fsfb_pkg::fsfb_sel_e decode(
    input logic [fsfb_pkg::ADDR_W-1:0] addr
  );
    logic [9:0] idx;
    idx = addr[fsfb_pkg::ADDR_W-1:2];
    if (idx == fsfb_pkg::CONV_IDX) begin
      decode = fsfb_pkg::SEL_CONV;
    end else if (idx == fsfb_pkg::DIG_IDX) begin
      decode = fsfb_pkg::SEL_DIG;
    end else if (idx == fsfb_pkg::IRQ_STAT_IDX) begin
      decode = fsfb_pkg::SEL_IRQ_STAT;
    end else if (idx == fsfb_pkg::IRQ_CLR_IDX) begin
      decode = fsfb_pkg::SEL_IRQ_CLR;
    end else if (idx == fsfb_pkg::IRQ_EN_IDX) begin
      decode = fsfb_pkg::SEL_IRQ_EN;
    end else begin
      decode = fsfb_pkg::SEL_NONE;
    end
  endfunction

  // ==========================================================
  // write channel state
  logic awready_ff;
  logic wready_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [fsfb_pkg::ADDR_W-1:0] waddr_ff;
  logic [fsfb_pkg::REG_W-1:0] wdata_ff;
  logic [1:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire;
  fsfb_pkg::fsfb_sel_e wr_sel;
  logic [fsfb_pkg::REG_W-1:0] wr_ones;

  // read channel state
  logic arready_ff;
  logic rvalid_ff;
  logic [fsfb_pkg::DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  fsfb_pkg::fsfb_sel_e rd_sel;

  // flag state and register images
  logic [fsfb_pkg::CONV_W-1:0] conv_flag_n;
  logic [fsfb_pkg::DIG_W-1:0] dig_flag_n;
  logic [fsfb_pkg::CONV_W-1:0] conv_restore;
  logic [fsfb_pkg::DIG_W-1:0] dig_restore;
  logic [fsfb_pkg::REG_W-1:0] conv_value;
  logic [fsfb_pkg::REG_W-1:0] dig_value;
  logic otp_bank_ff;
  logic otp_caught_ff;

  // interrupt state
  logic [fsfb_pkg::IRQ_W-1:0] irq_status_ff;
  logic [fsfb_pkg::IRQ_W-1:0] irq_enable_ff;
  logic [fsfb_pkg::IRQ_W-1:0] irq_events;
  logic irq_ff;

  // ==========================================================
  // write address: taken once, held until the write lands, next one only after the response is gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'h0;
      aw_held_ff <= 1'h0;
      waddr_ff <= '0;
    end else if (ce) begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'h0;
        aw_held_ff <= 1'h1;
        waddr_ff <= awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'h0;
      end else if (!aw_held_ff && !bvalid_ff) begin
        awready_ff <= 1'h1;
      end
    end
  end

  // write data: only the low two lanes carry register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'h0;
      w_held_ff <= 1'h0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (ce) begin
      if (wvalid && wready_ff) begin
        wready_ff <= 1'h0;
        w_held_ff <= 1'h1;
        wdata_ff <= wdata[fsfb_pkg::REG_W-1:0];
        wstrb_ff <= wstrb[1:0];
      end else if (wr_fire) begin
        w_held_ff <= 1'h0;
      end else if (!w_held_ff && !bvalid_ff) begin
        wready_ff <= 1'h1;
      end
    end
  end

  // the write lands once both halves are in, address and data in any order
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_sel = decode(waddr_ff);
  assign wr_ones = wdata_ff & {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // write response, unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'h0;
      bresp_ff <= fsfb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_ff <= 1'h1;
        bresp_ff <= (wr_sel == fsfb_pkg::SEL_NONE) ?
                    fsfb_pkg::RESP_SLVERR : fsfb_pkg::RESP_OKAY;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // ==========================================================
  // restore pulses: a one written to a flag bit, zeros do nothing
  always_comb begin
    conv_restore = '0;
    dig_restore = '0;
    if (wr_fire && wr_sel == fsfb_pkg::SEL_CONV) begin
      conv_restore = {wr_ones[fsfb_pkg::CONV_SHUNT_A_BIT],
                      wr_ones[fsfb_pkg::CONV_SHUNT_B_BIT],
                      wr_ones[fsfb_pkg::CONV_AUX_BIT],
                      wr_ones[fsfb_pkg::CONV_FREQ_BIT],
                      wr_ones[fsfb_pkg::CONV_DIAG_WD_BIT],
                      wr_ones[fsfb_pkg::CONV_MAIN_WD_BIT]}; // RULE4
    end
    if (wr_fire && wr_sel == fsfb_pkg::SEL_DIG) begin
      dig_restore = {wr_ones[fsfb_pkg::DIG_REGION_ONE_BIT],
                     wr_ones[fsfb_pkg::DIG_REGION_TWO_BIT],
                     wr_ones[fsfb_pkg::DIG_REGION_THREE_BIT],
                     wr_ones[fsfb_pkg::DIG_MEMORY_BIT]}; // RULE10
    end
  end

  // converter and clock faults, struct order matches bits 5..0
  fsfb_flag_bank #(
    .W(fsfb_pkg::CONV_W)
  ) u_conv_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .fault(conv_fault), // RULE1 RULE2 RULE3 RULE5 RULE6 RULE7
    .restore(conv_restore),
    .flag_n(conv_flag_n)
  );

  // region and memory checksum faults
  fsfb_flag_bank #(
    .W(fsfb_pkg::DIG_W)
  ) u_dig_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .fault(dig_fault), // RULE11 RULE12
    .restore(dig_restore),
    .flag_n(dig_flag_n)
  );

  // ==========================================================
  // loaded bank caught once after reset release, not at the reset edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      otp_bank_ff <= fsfb_pkg::OTP_BANK_RESET;
      otp_caught_ff <= 1'h0;
    end else if (ce && !otp_caught_ff) begin
      otp_bank_ff <= otp_bank_primary; // RULE13
      otp_caught_ff <= 1'h1;
    end
  end

  // register images, reserved bits come from fixed patterns
  always_comb begin
    conv_value = fsfb_pkg::CONV_RSVD; // RULE8
    conv_value[fsfb_pkg::CONV_SHUNT_A_BIT] = conv_flag_n[5]; // RULE1
    conv_value[fsfb_pkg::CONV_SHUNT_B_BIT] = conv_flag_n[4]; // RULE2
    conv_value[fsfb_pkg::CONV_AUX_BIT] = conv_flag_n[3]; // RULE3
    conv_value[fsfb_pkg::CONV_FREQ_BIT] = conv_flag_n[2]; // RULE5
    conv_value[fsfb_pkg::CONV_DIAG_WD_BIT] = conv_flag_n[1]; // RULE6
    conv_value[fsfb_pkg::CONV_MAIN_WD_BIT] = conv_flag_n[0]; // RULE7
    dig_value = '0; // RULE10
    dig_value[fsfb_pkg::DIG_REGION_ONE_BIT] = dig_flag_n[3]; // RULE11
    dig_value[fsfb_pkg::DIG_REGION_TWO_BIT] = dig_flag_n[2];
    dig_value[fsfb_pkg::DIG_REGION_THREE_BIT] = dig_flag_n[1];
    dig_value[fsfb_pkg::DIG_ZERO_BIT] = 1'h0;
    dig_value[fsfb_pkg::DIG_MEMORY_BIT] = dig_flag_n[0]; // RULE12
    dig_value[fsfb_pkg::DIG_OTP_BANK_BIT] = otp_bank_ff; // RULE13
  end

  // ==========================================================
  // interrupt: each detection sets a sticky bit; bank bit is no event
  assign irq_events = {conv_fault, dig_fault}; // RULE13

  // status sets win over a same-cycle clear so no event is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= '0;
    end else if (ce) begin
      if (wr_fire && wr_sel == fsfb_pkg::SEL_IRQ_CLR) begin
        irq_status_ff <= (irq_status_ff & ~wr_ones[fsfb_pkg::IRQ_W-1:0])
                         | irq_events;
      end else begin
        irq_status_ff <= irq_status_ff | irq_events;
      end
    end
  end

  // enable register, plain read/write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_ff <= fsfb_pkg::IRQ_EN_RESET;
    end else if (ce && wr_fire && wr_sel == fsfb_pkg::SEL_IRQ_EN) begin
      irq_enable_ff <= (irq_enable_ff &
                        ~{{2{wstrb_ff[1]}}, {8{wstrb_ff[0]}}})
                       | (wr_ones[fsfb_pkg::IRQ_W-1:0]);
    end
  end

  // registered so the pin comes from a flop, one cycle behind status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'h0;
    end else if (ce) begin
      irq_ff <= |(irq_status_ff & irq_enable_ff);
    end
  end

  // ==========================================================
  // read path: one read at a time, data one cycle after the address
  assign rd_sel = decode(araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'h0;
      rvalid_ff <= 1'h0;
      rdata_ff <= '0;
      rresp_ff <= fsfb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'h0;
        rvalid_ff <= 1'h1;
        rresp_ff <= fsfb_pkg::RESP_OKAY;
        rdata_ff <= '0;
        unique case (rd_sel)
          fsfb_pkg::SEL_CONV: rdata_ff[15:0] <= conv_value; // RULE8
          fsfb_pkg::SEL_DIG: rdata_ff[15:0] <= dig_value; // RULE9
          fsfb_pkg::SEL_IRQ_STAT: rdata_ff[9:0] <= irq_status_ff;
          fsfb_pkg::SEL_IRQ_CLR: rdata_ff <= '0;
          fsfb_pkg::SEL_IRQ_EN: rdata_ff[9:0] <= irq_enable_ff;
          fsfb_pkg::SEL_NONE: rresp_ff <= fsfb_pkg::RESP_SLVERR;
        endcase
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'h0;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'h1;
      end
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign irq = irq_ff;

  // ==========================================================
  // checks on the register images
  property p_shunt_a;
    @(posedge aclk) disable iff (!aresetn)
    ce && conv_fault.shunt_a |=> !conv_value[15];
  endproperty
  a_shunt_a: assert property (p_shunt_a) // RULE1
    else $error("first shunt overrange not latched");

  property p_shunt_b;
    @(posedge aclk) disable iff (!aresetn)
    ce && conv_fault.shunt_b |=> !conv_value[14];
  endproperty
  a_shunt_b: assert property (p_shunt_b) // RULE2
    else $error("second shunt overrange not latched");

  property p_aux;
    @(posedge aclk) disable iff (!aresetn)
    ce && conv_fault.aux |=> !conv_value[13];
  endproperty
  a_aux: assert property (p_aux) // RULE3
    else $error("auxiliary overrange not latched");

  property p_clock_faults;
    @(posedge aclk) disable iff (!aresetn)
    ce && (conv_fault.freq || conv_fault.diag_wd || conv_fault.main_wd)
    |=> (conv_value[2:0] & ~$past({conv_fault.freq,
         conv_fault.diag_wd, conv_fault.main_wd})) == conv_value[2:0];
  endproperty
  a_clock_faults: assert property (p_clock_faults) // RULE5
    else $error("clock fault not latched low");

  property p_conv_reserved;
    @(posedge aclk) disable iff (!aresetn)
    ce && arvalid && arready_ff && rd_sel == fsfb_pkg::SEL_CONV
    |=> rdata_ff[12:3] == fsfb_pkg::CONV_RSVD[12:3] &&
        rdata_ff[31:16] == 16'h0000;
  endproperty
  a_conv_reserved: assert property (p_conv_reserved) // RULE8
    else $error("converter reserved bits moved");

  property p_reset_values;
    @(posedge aclk)
    !aresetn && ce |=> conv_value == fsfb_pkg::CONV_RESET &&
                 dig_value == fsfb_pkg::DIG_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values) // RULE9
    else $error("register reset value wrong");

  property p_dig_fixed;
    @(posedge aclk) disable iff (!aresetn)
    ce && arvalid && arready_ff && rd_sel == fsfb_pkg::SEL_DIG
    |=> !rdata_ff[12] && rdata_ff[9:0] == 10'h000;
  endproperty
  a_dig_fixed: assert property (p_dig_fixed) // RULE10
    else $error("integrity reserved bits not zero");

  property p_region_one;
    @(posedge aclk) disable iff (!aresetn)
    ce && dig_fault.region_one |=> !dig_value[15];
  endproperty
  a_region_one: assert property (p_region_one) // RULE11
    else $error("region one checksum fault not latched");

  property p_memory;
    @(posedge aclk) disable iff (!aresetn)
    ce && dig_fault.internal_memory |=> !dig_value[11];
  endproperty
  a_memory: assert property (p_memory) // RULE12
    else $error("memory checksum fault not latched");

  property p_bank_steady;
    @(posedge aclk) disable iff (!aresetn)
    otp_caught_ff |=> $stable(otp_bank_ff) && otp_caught_ff;
  endproperty
  a_bank_steady: assert property (p_bank_steady) // RULE13
    else $error("bank indication changed after capture");

  property p_write_response;
    @(posedge aclk) disable iff (!aresetn)
    ce && wr_fire |=> bvalid_ff;
  endproperty
  a_write_response: assert property (p_write_response)
    else $error("write taken without response");

endmodule

// file: fsfb_tb.sv
// self-checking testbench for the fault status flag bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // byte addresses, four times the register index
  localparam logic [11:0] A_CONV = {fsfb_pkg::CONV_IDX, 2'h0};
  localparam logic [11:0] A_DIG = {fsfb_pkg::DIG_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {fsfb_pkg::IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] A_CLR = {fsfb_pkg::IRQ_CLR_IDX, 2'h0};
  localparam logic [11:0] A_EN = {fsfb_pkg::IRQ_EN_IDX, 2'h0};
  localparam logic [11:0] A_NONE = 12'h3FC;
  localparam logic [1:0] OK = fsfb_pkg::RESP_OKAY;
  // run is about three hundred cycles, so this only catches a hang
  localparam int TIMEOUT = 8000;
  // flag bit of each detector, struct order msb first
  localparam int CPOS [6] = '{fsfb_pkg::CONV_SHUNT_A_BIT,
    fsfb_pkg::CONV_SHUNT_B_BIT, fsfb_pkg::CONV_AUX_BIT,
    fsfb_pkg::CONV_FREQ_BIT, fsfb_pkg::CONV_DIAG_WD_BIT,
    fsfb_pkg::CONV_MAIN_WD_BIT};
  localparam int DPOS [4] = '{fsfb_pkg::DIG_REGION_ONE_BIT,
    fsfb_pkg::DIG_REGION_TWO_BIT, fsfb_pkg::DIG_REGION_THREE_BIT,
    fsfb_pkg::DIG_MEMORY_BIT};

  logic aclk;
  logic aresetn;
  logic ce;
  logic otp_bank_primary;
  fsfb_pkg::fsfb_conv_fault_s conv_fault;
  fsfb_pkg::fsfb_dig_fault_s dig_fault;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic [2:0] awprot;
  logic [2:0] arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  fsfb_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .conv_fault(conv_fault), .dig_fault(dig_fault),
    .otp_bank_primary(otp_bank_primary),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq)
  );

  // ==========================================================
  // clock and hang guard
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      failures++;
      close_out();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // one-cycle detector pulse, then a quiet edge
  task automatic pulse(input logic [5:0] c, input logic [3:0] d);
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(c);
    dig_fault <= fsfb_pkg::fsfb_dig_fault_s'(d);
    @(posedge aclk);
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(6'h00);
    dig_fault <= fsfb_pkg::fsfb_dig_fault_s'(4'h0);
    @(posedge aclk);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    otp_bank_primary = 1'b1;
    conv_fault = fsfb_pkg::fsfb_conv_fault_s'(6'h00);
    dig_fault = fsfb_pkg::fsfb_dig_fault_s'(4'h0);
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values
    rd(A_CONV, 32'h0000FC07, OK);
    rd(A_DIG, 32'h0000EC00, OK);
    rd(A_EN, 32'h00000000, OK);
    // every flag low, zeros written, then all ones restore
    pulse(6'h3F, 4'hF);
    wr(A_CONV, 32'h00000000, 4'hF, OK);
    rd(A_CONV, 32'h00001C00, OK);
    wr(A_DIG, 32'h00000000, 4'hF, OK);
    rd(A_DIG, 32'h00000400, OK);
    wr(A_CONV, 32'hFFFFFFFF, 4'hF, OK);
    rd(A_CONV, 32'h0000FC07, OK);
    wr(A_DIG, 32'hFFFFFFFF, 4'hF, OK);
    rd(A_DIG, 32'h0000EC00, OK);
    wr(A_CLR, 32'h000003FF, 4'hF, OK);
    // each converter and clock detector alone
    for (int i = 0; i < 6; i++) begin
      pulse(6'h20 >> i, 4'h0);
      rd(A_CONV, 32'h0000FC07 & ~(32'h1 << CPOS[i]), OK);
      rd(A_STAT, 32'h00000200 >> i, OK);
      wr(A_CLR, 32'h000003FF, 4'hF, OK);
      wr(A_CONV, 32'h1 << CPOS[i], 4'hF, OK);
      rd(A_CONV, 32'h0000FC07, OK);
    end
    // each checksum detector alone
    for (int j = 0; j < 4; j++) begin
      pulse(6'h00, 4'h8 >> j);
      rd(A_DIG, 32'h0000EC00 & ~(32'h1 << DPOS[j]), OK);
      rd(A_STAT, 32'h00000008 >> j, OK);
      wr(A_CLR, 32'h000003FF, 4'hF, OK);
      wr(A_DIG, 32'h1 << DPOS[j], 4'hF, OK);
      rd(A_DIG, 32'h0000EC00, OK);
    end
    // byte strobes restore only their own half
    pulse(6'h21, 4'h0);
    wr(A_CONV, 32'h0000FFFF, 4'h1, OK);
    rd(A_CONV, 32'h00007C07, OK);
    wr(A_CONV, 32'h0000FFFF, 4'h2, OK);
    rd(A_CONV, 32'h0000FC07, OK);
    // detector held through a restore: the fault must win
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(6'h08);
    @(posedge aclk);
    wr(A_CONV, 32'h00002000, 4'hF, OK);
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(6'h00);
    @(posedge aclk);
    rd(A_CONV, 32'h0000DC07, OK);
    wr(A_CONV, 32'h00002000, 4'hF, OK);
    rd(A_CONV, 32'h0000FC07, OK);
    // clock enable low hides a detector pulse
    ce <= 1'b0;
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(6'h10);
    repeat (2) @(posedge aclk);
    conv_fault <= fsfb_pkg::fsfb_conv_fault_s'(6'h00);
    ce <= 1'b1;
    @(posedge aclk);
    rd(A_CONV, 32'h0000FC07, OK);
    // unmapped place answers with an error and no data
    wr(A_NONE, 32'hFFFFFFFF, 4'hF, fsfb_pkg::RESP_SLVERR);
    rd(A_NONE, 32'h00000000, fsfb_pkg::RESP_SLVERR);
    // interrupt raised masked, then enabled, then cleared
    wr(A_CLR, 32'h000003FF, 4'hF, OK);
    pulse(6'h04, 4'h0);
    rd(A_STAT, 32'h00000040, OK);
    check({31'h0, irq}, 32'h0);
    wr(A_EN, 32'h00000040, 4'hF, OK);
    rd(A_EN, 32'h00000040, OK);
    check({31'h0, irq}, 32'h1);
    // enable lanes: an unstrobed upper lane must keep its bits
    wr(A_EN, 32'h00000300, 4'h2, OK);
    rd(A_EN, 32'h00000340, OK);
    wr(A_EN, 32'h00000040, 4'h1, OK);
    rd(A_EN, 32'h00000340, OK);
    check({31'h0, irq}, 32'h1);
    wr(A_CLR, 32'h00000040, 4'hF, OK);
    rd(A_STAT, 32'h00000000, OK);
    check({31'h0, irq}, 32'h0);
    wr(A_CONV, 32'h00000004, 4'hF, OK);
    rd(A_CONV, 32'h0000FC07, OK);
    // second reset with the backup bank loaded
    otp_bank_primary <= 1'b0;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_DIG, 32'h0000E800, OK);
    rd(A_STAT, 32'h00000000, OK);
    rd(A_EN, 32'h00000000, OK);
    close_out();
  end

endmodule
